// ---- eeprom_powerup_state.sv ----
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
// Operation
// [RULE_01] After power-on reset the device settles in standby, with no instruction or array access running.
// [RULE_02] After power-on the device is deselected and starts nothing until select has been seen high and then falls.
// [RULE_03] After power-on the hold condition is inactive.
// [RULE_04] Power-on reset clears the write permit latch to zero.
// [RULE_05] Power-on reset clears the write cycle active flag to zero.
// [RULE_06] The two block-protect bits are non-volatile and keep their value across power-on reset.
// [RULE_07] In the delivery state every array byte reads as FFh.
// [RULE_08] In the delivery state both block-protect bits are zero.
// [RULE_09] With the write permit latch at zero, array writes and status writes are rejected.
// [RULE_10] The write cycle active flag is one while a write cycle runs and zero otherwise; the status port shows it one cycle late.
// [RULE_11] Power-on reset sets all volatile state before the first select falling edge is honoured.
module eeprom_powerup_state #(
    parameter int ARRAY_DEPTH = 16,
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic selectN,
    input wire logic holdN,
    input wire logic [eeprom_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [eeprom_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [eeprom_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [eeprom_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output eeprom_pkg::status_t status
);
    import eeprom_pkg::*;

    localparam int IDX_W = $clog2(ARRAY_DEPTH);

    // True when the byte lies in the area that the protect bits cover:
    // upper quarter, upper half or the whole array.
    function automatic logic isProtected(input logic [1:0] prot,
                                         input logic [IDX_W-1:0] idx);
        int limit;
        begin
            case (prot)
                2'h1: limit = ARRAY_DEPTH - ARRAY_DEPTH / 4;
                2'h2: limit = ARRAY_DEPTH / 2;
                2'h3: limit = 0;
                default: limit = ARRAY_DEPTH;
            endcase
            isProtected = int'(idx) >= limit;
        end
    endfunction : isProtected

    powerState_t powerState_reg, powerState_next;
    logic selPrev_reg, selPrev_next;
    logic hold_reg, hold_next;
    logic standby_reg, standby_next;
    logic permit_reg, permit_next;
    logic active_reg, active_next;
    logic [31:0] cycleCnt_reg, cycleCnt_next;
    logic kindArray_reg, kindArray_next;
    logic [7:0] pendData_reg, pendData_next;
    logic [IDX_W-1:0] pendIdx_reg, pendIdx_next;
    logic [IDX_W-1:0] arrayIdx_reg, arrayIdx_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [ADDR_W-1:0] awAddr_reg, awAddr_next;
    logic [DATA_W-1:0] wData_reg, wData_next;
    logic lowLane_reg, lowLane_next;
    // Non-volatile storage: deliberately untouched by power-on reset.
    logic [1:0] protect_reg, protect_next;
    logic [7:0] arrayMem [ARRAY_DEPTH];
    logic [7:0] arrayMem_next [ARRAY_DEPTH];
    logic wrFire, instrOk, wrStart, factoryFire, cycleEnd;
    status_t statusNow;

    always_comb
    begin
        powerState_next = powerState_reg;
        selPrev_next = selectN;
        permit_next = permit_reg;
        active_next = active_reg;
        cycleCnt_next = cycleCnt_reg;
        kindArray_next = kindArray_reg;
        pendData_next = pendData_reg;
        pendIdx_next = pendIdx_reg;
        arrayIdx_next = arrayIdx_reg;
        awready_next = awready_reg;
        wready_next = wready_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        awAddr_next = awAddr_reg;
        wData_next = wData_reg;
        lowLane_next = lowLane_reg;
        protect_next = protect_reg;
        arrayMem_next = arrayMem;
        wrStart = 1'b0;
        factoryFire = 1'b0;
        cycleEnd = 1'b0;
        case (powerState_reg)
            PS_INIT: powerState_next = PS_STANDBY; // [RULE_01] [RULE_11]
            PS_STANDBY:
                if (selPrev_reg && !selectN)
                    powerState_next = PS_ACTIVE; // [RULE_02]
            PS_ACTIVE:
                if (selectN)
                    powerState_next = PS_STANDBY;
            default: powerState_next = PS_INIT;
        endcase
        // Hold only means anything while selected, never straight from reset.
        hold_next = (powerState_next == PS_ACTIVE) && !holdN; // [RULE_03]
        instrOk = (powerState_reg == PS_ACTIVE) && !hold_reg;
        if (active_reg)
        begin
            if (cycleCnt_reg <= 32'h1)
            begin
                cycleEnd = 1'b1;
                active_next = 1'b0; // [RULE_10]
                permit_next = 1'b0;
                if (kindArray_reg)
                    arrayMem_next[pendIdx_reg] = pendData_reg;
                else
                    protect_next = pendData_reg[WRSTAT_PROTECT_LSB +: 2];
            end
            cycleCnt_next = cycleCnt_reg - 32'h1;
        end
        if (s_axi_awvalid && awready_reg)
        begin
            awAddr_next = s_axi_awaddr;
            awready_next = 1'b0;
        end
        if (s_axi_wvalid && wready_reg)
        begin
            wData_next = s_axi_wdata;
            lowLane_next = s_axi_wstrb[0];
            wready_next = 1'b0;
        end
        wrFire = !awready_reg && !wready_reg && !bvalid_reg;
        if (wrFire)
        begin
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            case (awAddr_reg)
                CTRL_OFFS:
                    if (lowLane_reg)
                    begin
                        if (!instrOk || active_reg)
                            bresp_next = RESP_SLVERR;
                        else if (wData_reg[CTRL_FACTORY_BIT])
                        begin
                            factoryFire = 1'b1;
                            protect_next = FACTORY_PROTECT; // [RULE_08]
                            for (int i = 0; i < ARRAY_DEPTH; i++)
                                arrayMem_next[i] = BLANK_BYTE; // [RULE_07]
                        end
                        else if (wData_reg[CTRL_CLR_PERMIT_BIT])
                            permit_next = 1'b0;
                        else if (wData_reg[CTRL_SET_PERMIT_BIT])
                            permit_next = 1'b1;
                    end
                WRSTAT_OFFS, ARRAY_DATA_OFFS:
                    if (lowLane_reg)
                    begin
                        // Latch clear or a running cycle refuses the write.
                        if (!instrOk || !permit_reg || active_reg) // [RULE_09]
                            bresp_next = RESP_SLVERR;
                        else if (awAddr_reg == ARRAY_DATA_OFFS
                                 && isProtected(protect_reg, arrayIdx_reg))
                            bresp_next = RESP_SLVERR;
                        else
                        begin
                            wrStart = 1'b1;
                            active_next = 1'b1; // [RULE_10]
                            cycleCnt_next = 32'(WRITE_CYCLES);
                            kindArray_next = awAddr_reg == ARRAY_DATA_OFFS;
                            pendData_next = wData_reg[7:0];
                            pendIdx_next = arrayIdx_reg;
                        end
                    end
                ARRAY_ADDR_OFFS:
                    if (lowLane_reg)
                        arrayIdx_next = wData_reg[IDX_W-1:0];
                STATUS_OFFS: ;
                default: bresp_next = RESP_DECERR;
            endcase
        end
        if (bvalid_reg && s_axi_bready)
        begin
            bvalid_next = 1'b0;
            awready_next = 1'b1;
            wready_next = 1'b1;
        end
        if (s_axi_arvalid && arready_reg)
        begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = '0;
            case (s_axi_araddr)
                CTRL_OFFS, WRSTAT_OFFS: ;
                STATUS_OFFS: rdata_next = DATA_W'(statusNow);
                ARRAY_ADDR_OFFS: rdata_next = DATA_W'(arrayIdx_reg);
                ARRAY_DATA_OFFS:
                    // The array cannot be read during a write cycle.
                    if (active_reg)
                        rresp_next = RESP_SLVERR;
                    else
                        rdata_next = DATA_W'(arrayMem[arrayIdx_reg]);
                default: rresp_next = RESP_DECERR;
            endcase
        end
        if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
        standby_next = (powerState_next != PS_ACTIVE) && !active_next;
    end

    always_comb
    begin
        statusNow.standby = standby_reg;
        statusNow.holdActive = hold_reg;
        statusNow.selected = powerState_reg == PS_ACTIVE;
        statusNow.protectSize = protect_reg;
        statusNow.writePermitLatch = permit_reg;
        statusNow.writeCycleActive = active_reg;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            powerState_reg <= PS_INIT; // [RULE_11]
            selPrev_reg <= 1'b0; // [RULE_02]
            hold_reg <= 1'b0; // [RULE_03]
            standby_reg <= 1'b1; // [RULE_01]
            permit_reg <= 1'b0; // [RULE_04]
            active_reg <= 1'b0; // [RULE_05]
            cycleCnt_reg <= 32'h0;
            kindArray_reg <= 1'b0;
            pendData_reg <= 8'h00;
            pendIdx_reg <= '0;
            arrayIdx_reg <= '0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
            awAddr_reg <= '0;
            wData_reg <= '0;
            lowLane_reg <= 1'b0;
            status <= '0;
        end
        else if (clkEn)
        begin
            powerState_reg <= powerState_next;
            selPrev_reg <= selPrev_next;
            hold_reg <= hold_next;
            standby_reg <= standby_next;
            permit_reg <= permit_next;
            active_reg <= active_next;
            cycleCnt_reg <= cycleCnt_next;
            kindArray_reg <= kindArray_next;
            pendData_reg <= pendData_next;
            pendIdx_reg <= pendIdx_next;
            arrayIdx_reg <= arrayIdx_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            awAddr_reg <= awAddr_next;
            wData_reg <= wData_next;
            lowLane_reg <= lowLane_next;
            status <= statusNow;
        end
    end

    // No reset here: these bits model non-volatile cells.
    always_ff @(posedge clk)
    begin
        if (clkEn)
        begin
            protect_reg <= protect_next; // [RULE_06]
            arrayMem <= arrayMem_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    a_init_to_standby: assert property ( // [RULE_01] [RULE_11]
        @(posedge clk) disable iff (!arst_n)
        (powerState_reg == PS_INIT && clkEn) |=>
            (powerState_reg == PS_STANDBY && standby_reg))
        else $error("Init did not settle in standby.");
    a_select_edge_needed: assert property ( // [RULE_02]
        @(posedge clk) disable iff (!arst_n)
        (powerState_reg != PS_ACTIVE && !(selPrev_reg && !selectN))
            |=> powerState_reg != PS_ACTIVE)
        else $error("Selected without a select falling edge.");
    a_hold_needs_select: assert property ( // [RULE_03]
        @(posedge clk) disable iff (!arst_n)
        hold_reg |-> powerState_reg == PS_ACTIVE)
        else $error("Hold active while deselected.");
    a_init_permit_clear: assert property ( // [RULE_04]
        @(posedge clk) disable iff (!arst_n)
        powerState_reg == PS_INIT |-> !permit_reg && !status.writePermitLatch)
        else $error("Write permit latch set after reset.");
    a_init_active_clear: assert property ( // [RULE_05]
        @(posedge clk) disable iff (!arst_n)
        powerState_reg == PS_INIT |-> !active_reg && cycleCnt_reg == 32'h0)
        else $error("Write cycle flag set after reset.");
    a_protect_kept: assert property ( // [RULE_06]
        @(posedge clk) disable iff (!arst_n)
        (clkEn && !cycleEnd && !factoryFire) |=> $stable(protect_reg))
        else $error("Protect bits changed outside a write.");
    a_factory_blank: assert property ( // [RULE_07] [RULE_08]
        @(posedge clk) disable iff (!arst_n)
        (factoryFire && clkEn) |=>
            (arrayMem[0] == BLANK_BYTE && protect_reg == FACTORY_PROTECT))
        else $error("Delivery state not restored.");
    a_write_rejected: assert property ( // [RULE_09]
        @(posedge clk) disable iff (!arst_n)
        wrStart |-> permit_reg && !active_reg && instrOk)
        else $error("Write started without permission.");
    a_write_refused: assert property ( // [RULE_09]
        @(posedge clk) disable iff (!arst_n)
        (wrFire && clkEn && lowLane_reg && !permit_reg
            && (awAddr_reg == WRSTAT_OFFS || awAddr_reg == ARRAY_DATA_OFFS))
            |=> bresp_reg == RESP_SLVERR && !active_reg)
        else $error("Write accepted with the permit latch clear.");
    a_cycle_active: assert property ( // [RULE_10]
        @(posedge clk) disable iff (!arst_n)
        (wrStart && clkEn) |=> active_reg ##0 status.writeCycleActive == 1'b0
            ##1 (status.writeCycleActive || !$past(clkEn)))
        else $error("Write cycle flag not raised.");
    a_cycle_end_clears: assert property ( // [RULE_10]
        @(posedge clk) disable iff (!arst_n)
        $fell(active_reg) |-> !permit_reg && cycleCnt_reg == 32'h0)
        else $error("Write cycle ended badly.");

endmodule : eeprom_powerup_state

// ---- eeprom_pkg.sv ----
package eeprom_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] CTRL_OFFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFS = 8'h04;
    localparam logic [ADDR_W-1:0] WRSTAT_OFFS = 8'h08;
    localparam logic [ADDR_W-1:0] ARRAY_ADDR_OFFS = 8'h0C;
    localparam logic [ADDR_W-1:0] ARRAY_DATA_OFFS = 8'h10;

    // Control register command bits.
    localparam int CTRL_SET_PERMIT_BIT = 0;
    localparam int CTRL_CLR_PERMIT_BIT = 1;
    localparam int CTRL_FACTORY_BIT = 2;

    // Block-protect field position in the status-write data.
    localparam int WRSTAT_PROTECT_LSB = 2;

    // Delivery state of the non-volatile storage.
    localparam logic [7:0] BLANK_BYTE = 8'hFF;
    localparam logic [1:0] FACTORY_PROTECT = 2'h0;

    // Self-timed write cycle.
    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_TIME_US = 5;
    localparam int WRITE_CYCLES = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {PS_INIT, PS_STANDBY, PS_ACTIVE} powerState_t;

    // The first field is the top bit: standby is bit 6, cycle flag bit 0.
    typedef struct packed {
        logic standby;
        logic holdActive;
        logic selected;
        logic [1:0] protectSize;
        logic writePermitLatch;
        logic writeCycleActive;
    } status_t;

endpackage : eeprom_pkg

// ---- spi_host_model.sv ----
`timescale 1ns/10ps
module spi_host_model (
    input wire logic clk,
    input wire logic selReq,
    input wire logic holdReq,
    output logic selectN,
    output logic holdN
);
    // The host pins change only just after a rising edge, so each level is
    // seen for whole cycles. Hold is let go whenever the host deselects.
    initial
    begin
        selectN = 1'b1;
        holdN = 1'b1;
    end

    always @(posedge clk)
    begin
        selectN <= !selReq;
        holdN <= !(holdReq && selReq);
    end
endmodule : spi_host_model

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
    import eeprom_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic selReq = 1'b0;
    logic holdReq = 1'b0;
    logic selectN;
    logic holdN;
    logic [7:0] awAddr = 8'h00;
    logic awValid = 1'b0;
    logic awReady;
    logic [31:0] wData = 32'h0;
    logic [3:0] wStrb = 4'hF;
    logic wValid = 1'b0;
    logic wReady;
    logic [1:0] bResp;
    logic bValid;
    logic bReady = 1'b0;
    logic [7:0] arAddr = 8'h00;
    logic arValid = 1'b0;
    logic arReady;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic rValid;
    logic rReady = 1'b0;
    status_t status;
    int errCount = 0;
    int nChecks = 0;

    always #5 clk = !clk;

    spi_host_model i_host (.clk(clk), .selReq(selReq), .holdReq(holdReq),
        .selectN(selectN), .holdN(holdN));

    // A short write cycle keeps the run brief; completion is polled, but the
    // status check and SLVERR read during the cycle need it still running.
    eeprom_powerup_state #(.ARRAY_DEPTH(16), .WRITE_CYCLES(8)) i_dut (
        .clk(clk), .arst_n(arst_n), .clkEn(1'b1), .selectN(selectN),
        .holdN(holdN), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .status(status));

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] expResp);
        int n;
        logic [1:0] r;
        n = 0;
        r = 2'h1;
        @(posedge clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (n < 60)
        begin
            @(posedge clk);
            n++;
            if (awValid && awReady)
                awValid <= 1'b0;
            if (wValid && wReady)
                wValid <= 1'b0;
            if (bValid)
            begin
                bReady <= 1'b0;
                r = bResp;
                n = 99;
            end
        end
        check("bresp", 32'(r), 32'(expResp));
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] a, input logic [1:0] expResp,
                           output logic [31:0] d);
        int n;
        logic [1:0] r;
        n = 0;
        r = 2'h1;
        d = 32'hDEADBEEF;
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        while (n < 60)
        begin
            @(posedge clk);
            n++;
            if (arValid && arReady)
                arValid <= 1'b0;
            if (rValid)
            begin
                rReady <= 1'b0;
                r = rResp;
                d = rData;
                n = 99;
            end
        end
        check("rresp", 32'(r), 32'(expResp));
    endtask : axiRead

    // Order: standby, hold, selected, permit latch, cycle active.
    task automatic chkPins(input logic [4:0] exp);
        @(negedge clk);
        check("status", 32'({status.standby, status.holdActive,
            status.selected, status.writePermitLatch,
            status.writeCycleActive}), 32'(exp));
    endtask : chkPins

    task automatic pinSet(input logic sel, input logic hold);
        @(posedge clk);
        selReq <= sel;
        holdReq <= hold;
        repeat (4) @(posedge clk);
    endtask : pinSet

    task automatic waitIdle;
        int n;
        n = 0;
        @(negedge clk);
        while (status.writeCycleActive !== 1'b0 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        check("cycle done", 32'(n < 200), 32'h1);
    endtask : waitIdle

    task automatic doReset;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : doReset

    task automatic test_powerup;
        logic [31:0] d;
        chkPins(5'b10000);
        axiWrite(CTRL_OFFS, 32'h1, RESP_SLVERR);
        axiRead(8'h20, RESP_DECERR, d);
        $display("test powerup done");
    endtask : test_powerup

    task automatic test_delivery;
        logic [31:0] d;
        pinSet(1'b1, 1'b0);
        axiWrite(CTRL_OFFS, 32'h4, RESP_OKAY);
        axiRead(STATUS_OFFS, RESP_OKAY, d);
        check("protect", 32'(d[3:2]), 32'h0);
        for (int i = 0; i < 16; i++)
        begin
            axiWrite(ARRAY_ADDR_OFFS, 32'(i), RESP_OKAY);
            axiRead(ARRAY_DATA_OFFS, RESP_OKAY, d);
            check("array byte", 32'(d[7:0]), 32'hFF);
        end
        $display("test delivery done");
    endtask : test_delivery

    task automatic test_write_cycle;
        logic [31:0] d;
        // A write with byte lane 0 off is dropped but still answered OKAY.
        @(posedge clk);
        wStrb <= 4'h0;
        axiWrite(CTRL_OFFS, 32'h1, RESP_OKAY);
        wStrb <= 4'hF;
        chkPins(5'b00100);
        axiWrite(ARRAY_ADDR_OFFS, 32'h3, RESP_OKAY);
        axiWrite(ARRAY_DATA_OFFS, 32'h5A, RESP_SLVERR);
        axiWrite(WRSTAT_OFFS, 32'hC, RESP_SLVERR);
        axiWrite(CTRL_OFFS, 32'h1, RESP_OKAY);
        chkPins(5'b00110);
        axiWrite(ARRAY_DATA_OFFS, 32'h5A, RESP_OKAY);
        chkPins(5'b00111);
        axiRead(ARRAY_DATA_OFFS, RESP_SLVERR, d);
        waitIdle();
        chkPins(5'b00100);
        axiRead(ARRAY_DATA_OFFS, RESP_OKAY, d);
        check("array byte", 32'(d[7:0]), 32'h5A);
        $display("test write cycle done");
    endtask : test_write_cycle

    task automatic test_hold;
        pinSet(1'b1, 1'b1);
        chkPins(5'b01100);
        axiWrite(CTRL_OFFS, 32'h1, RESP_SLVERR);
        pinSet(1'b1, 1'b0);
        chkPins(5'b00100);
        $display("test hold done");
    endtask : test_hold

    task automatic test_protect_reset;
        logic [31:0] d;
        axiWrite(CTRL_OFFS, 32'h1, RESP_OKAY);
        axiWrite(WRSTAT_OFFS, 32'h8, RESP_OKAY);
        waitIdle();
        axiWrite(CTRL_OFFS, 32'h1, RESP_OKAY);
        // Select stays low across reset, so no fresh falling edge exists.
        doReset();
        chkPins(5'b10000);
        check("protect pins", 32'(status.protectSize), 32'h2);
        axiRead(STATUS_OFFS, RESP_OKAY, d);
        check("protect", 32'(d[3:2]), 32'h2);
        axiWrite(CTRL_OFFS, 32'h1, RESP_SLVERR);
        pinSet(1'b0, 1'b0);
        pinSet(1'b1, 1'b0);
        axiWrite(CTRL_OFFS, 32'h1, RESP_OKAY);
        $display("test protect reset done");
    endtask : test_protect_reset

    task automatic test_done;
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    initial
    begin
        #200us;
        errCount++;
        $display("mismatch watchdog expected finish seen timeout");
        test_done();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_powerup();
        test_delivery();
        test_write_cycle();
        test_hold();
        test_protect_reset();
        test_done();
    end
endmodule : testbench
